// file: hdl/ebm_exec.sv
`default_nettype none
module ebm_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic issue,
    input wire ebm_pkg::ebm_op_t op,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] imm_val,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] io_val,
    input wire logic [11:0] offset,
    input wire logic [15:0] abs_addr,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] stack_val,
    input wire logic next_two_word,
    // Sequencing
    output var logic ready,
    output var logic done,
    // Architectural state and results
    output var logic [15:0] pc,
    output var logic [7:0] status_flag_register,
    output var logic [7:0] result,
    output var logic result_we,
    output var logic [15:0] product,
    output var logic product_we,
    output var logic push,
    output var logic [15:0] push_addr,
    output var logic pop
);
    logic [2:0] cnt_r, cnt_nxt, cyc;
    logic ready_nxt, done_nxt, result_we_nxt, product_we_nxt, push_nxt, pop_nxt;
    logic [15:0] pc_nxt, product_nxt, push_addr_nxt, pc_inc, rel_tgt, skip_tgt;
    logic [7:0] status_flag_register_nxt, result_nxt;
    logic accept, skip_cnd, m_as, m_bs, m_frac, m_zero, m_carry;
    logic [15:0] m_prod;

    function automatic logic [7:0] cmp_flags(input logic [7:0] s, input logic [7:0] a,
                                             input logic [7:0] b, input logic cin,
                                             input logic chain);
        logic [8:0] d;
        logic [7:0] f;
        d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        f = s;
        f[ebm_pkg::FLAG_C] = d[8];
        f[ebm_pkg::FLAG_N] = d[7];
        f[ebm_pkg::FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        f[ebm_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
        // With borrow chaining a zero result keeps Z, so multi-byte compares work.
        f[ebm_pkg::FLAG_Z] = (d[7:0] == 8'h00) & (chain ? s[ebm_pkg::FLAG_Z] : 1'b1);
        f[ebm_pkg::FLAG_S] = f[ebm_pkg::FLAG_N] ^ f[ebm_pkg::FLAG_V];
        return f;
    endfunction : cmp_flags

    function automatic logic [7:0] logic_flags(input logic [7:0] s, input logic [7:0] r);
        logic [7:0] f;
        f = s;
        f[ebm_pkg::FLAG_Z] = (r == 8'h00);
        f[ebm_pkg::FLAG_N] = r[7];
        f[ebm_pkg::FLAG_V] = 1'b0;
        f[ebm_pkg::FLAG_S] = r[7];
        return f;
    endfunction : logic_flags

    function automatic logic br_taken(input ebm_pkg::ebm_op_t o, input logic [7:0] s,
                                      input logic [2:0] b);
        logic t;
        t = 1'b0;
        unique case (o)
            ebm_pkg::op_branch_if_flag_set: t = s[b];
            ebm_pkg::op_branch_if_flag_clear: t = ~s[b];
            ebm_pkg::op_branch_if_equal: t = s[ebm_pkg::FLAG_Z];
            ebm_pkg::op_branch_if_not_equal: t = ~s[ebm_pkg::FLAG_Z];
            ebm_pkg::op_branch_if_carry_set: t = s[ebm_pkg::FLAG_C];
            ebm_pkg::op_branch_if_lower: t = s[ebm_pkg::FLAG_C];
            ebm_pkg::op_branch_if_carry_clear: t = ~s[ebm_pkg::FLAG_C];
            ebm_pkg::op_branch_if_same_or_higher: t = ~s[ebm_pkg::FLAG_C];
            ebm_pkg::op_branch_if_negative: t = s[ebm_pkg::FLAG_N];
            ebm_pkg::op_branch_if_positive: t = ~s[ebm_pkg::FLAG_N];
            ebm_pkg::op_branch_if_signed_ge: begin
                t = ~(s[ebm_pkg::FLAG_N] ^ s[ebm_pkg::FLAG_V]);
            end
            ebm_pkg::op_branch_if_signed_lt: begin
                t = s[ebm_pkg::FLAG_N] ^ s[ebm_pkg::FLAG_V];
            end
            ebm_pkg::op_branch_if_half_carry_set: t = s[ebm_pkg::FLAG_H];
            ebm_pkg::op_branch_if_half_carry_clear: t = ~s[ebm_pkg::FLAG_H];
            ebm_pkg::op_branch_if_transfer_flag_set: t = s[ebm_pkg::FLAG_T];
            ebm_pkg::op_branch_if_transfer_flag_clear: t = ~s[ebm_pkg::FLAG_T];
            ebm_pkg::op_branch_if_overflow_set: t = s[ebm_pkg::FLAG_V];
            ebm_pkg::op_branch_if_overflow_clear: t = ~s[ebm_pkg::FLAG_V];
            default: t = 1'b0;
        endcase
        return t;
    endfunction : br_taken

    assign accept = issue & ready;
    assign pc_inc = pc + ebm_pkg::STEP_ONE;
    assign rel_tgt = pc_inc + {{4{offset[11]}}, offset};
    // A skip steps over a one-word or a two-word successor.
    assign skip_tgt = pc + (next_two_word ? ebm_pkg::STEP_THREE : ebm_pkg::STEP_TWO);
    assign m_as = (op == ebm_pkg::op_signed_product) || (op == ebm_pkg::op_mixed_sign_product)
        || (op == ebm_pkg::op_fraction_product_signed)
        || (op == ebm_pkg::op_fraction_product_mixed);
    assign m_bs = (op == ebm_pkg::op_signed_product)
        || (op == ebm_pkg::op_fraction_product_signed);
    assign m_frac = (op == ebm_pkg::op_fraction_product_unsigned)
        || (op == ebm_pkg::op_fraction_product_signed)
        || (op == ebm_pkg::op_fraction_product_mixed);

    ebm_mul u_mul (
        .a(rd_val),
        .b(rr_val),
        .a_signed(m_as),
        .b_signed(m_bs),
        .frac(m_frac),
        .product(m_prod),
        .zero(m_zero),
        .carry(m_carry)
    );

    always_comb begin
        pc_nxt = pc;
        status_flag_register_nxt = status_flag_register;
        result_nxt = result;
        result_we_nxt = 1'b0;
        product_nxt = product;
        product_we_nxt = 1'b0;
        push_nxt = 1'b0;
        push_addr_nxt = push_addr;
        pop_nxt = 1'b0;
        skip_cnd = 1'b0;
        cyc = ebm_pkg::CYC_ONE;
        cnt_nxt = (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
        if (accept) begin
            pc_nxt = pc_inc;
            unique case (op)
                ebm_pkg::op_test_zero_or_negative: begin
                    result_nxt = rd_val & rd_val;
                    result_we_nxt = 1'b1;
                    status_flag_register_nxt = logic_flags(status_flag_register, rd_val & rd_val);
                end
                ebm_pkg::op_zero_register: begin
                    result_nxt = rd_val ^ rd_val;
                    result_we_nxt = 1'b1;
                    status_flag_register_nxt = logic_flags(status_flag_register, rd_val ^ rd_val);
                end
                ebm_pkg::op_set_all_ones: begin
                    result_nxt = ebm_pkg::ALL_ONES;
                    result_we_nxt = 1'b1;
                end
                ebm_pkg::op_unsigned_product, ebm_pkg::op_signed_product,
                ebm_pkg::op_mixed_sign_product, ebm_pkg::op_fraction_product_unsigned,
                ebm_pkg::op_fraction_product_signed, ebm_pkg::op_fraction_product_mixed: begin
                    product_nxt = m_prod;
                    product_we_nxt = 1'b1;
                    status_flag_register_nxt[ebm_pkg::FLAG_Z] = m_zero;
                    status_flag_register_nxt[ebm_pkg::FLAG_C] = m_carry;
                    cyc = ebm_pkg::CYC_TWO;
                end
                ebm_pkg::op_relative_goto: begin
                    pc_nxt = rel_tgt;
                    cyc = ebm_pkg::CYC_TWO;
                end
                ebm_pkg::op_indirect_goto: begin
                    pc_nxt = z_ptr;
                    cyc = ebm_pkg::CYC_TWO;
                end
                ebm_pkg::op_absolute_goto: begin
                    pc_nxt = abs_addr;
                    cyc = ebm_pkg::CYC_THREE;
                end
                ebm_pkg::op_relative_subroutine_invoke, ebm_pkg::op_indirect_subroutine_invoke: begin
                    pc_nxt = (op == ebm_pkg::op_indirect_subroutine_invoke) ? z_ptr : rel_tgt;
                    push_nxt = 1'b1;
                    push_addr_nxt = pc_inc;
                    cyc = ebm_pkg::CYC_FOUR;
                end
                ebm_pkg::op_absolute_subroutine_invoke: begin
                    // The call itself is two words long, so the return skips both.
                    pc_nxt = abs_addr;
                    push_nxt = 1'b1;
                    push_addr_nxt = pc + ebm_pkg::STEP_TWO;
                    cyc = ebm_pkg::CYC_FIVE;
                end
                ebm_pkg::op_subroutine_exit, ebm_pkg::op_interrupt_handler_exit: begin
                    pc_nxt = stack_val;
                    pop_nxt = 1'b1;
                    if (op == ebm_pkg::op_interrupt_handler_exit) begin
                        status_flag_register_nxt[ebm_pkg::FLAG_I] = 1'b1;
                    end
                    cyc = ebm_pkg::CYC_FIVE;
                end
                ebm_pkg::op_compare_only: begin
                    status_flag_register_nxt = cmp_flags(status_flag_register, rd_val, rr_val, 1'b0, 1'b0);
                end
                ebm_pkg::op_compare_with_borrow: begin
                    status_flag_register_nxt = cmp_flags(status_flag_register, rd_val, rr_val, status_flag_register[ebm_pkg::FLAG_C], 1'b1);
                end
                ebm_pkg::op_compare_immediate: begin
                    status_flag_register_nxt = cmp_flags(status_flag_register, rd_val, imm_val, 1'b0, 1'b0);
                end
                ebm_pkg::op_skip_if_equal: skip_cnd = (rd_val == rr_val);
                ebm_pkg::op_skip_if_reg_bit_low: skip_cnd = ~rr_val[bit_sel];
                ebm_pkg::op_skip_if_reg_bit_high: skip_cnd = rr_val[bit_sel];
                ebm_pkg::op_skip_if_io_bit_low: skip_cnd = ~io_val[bit_sel];
                ebm_pkg::op_skip_if_io_bit_high: skip_cnd = io_val[bit_sel];
                default: begin
                    // Branches; an unused code falls through as a one-cycle no-op.
                    if (br_taken(op, status_flag_register, bit_sel)) begin
                        pc_nxt = rel_tgt;
                        cyc = ebm_pkg::CYC_TWO;
                    end
                end
            endcase
            if (skip_cnd) begin
                pc_nxt = skip_tgt;
                cyc = next_two_word ? ebm_pkg::CYC_THREE : ebm_pkg::CYC_TWO;
            end
            cnt_nxt = cyc - 3'h1;
        end
        ready_nxt = (cnt_nxt == 3'h0);
        done_nxt = (cnt_r == 3'h1) || (accept && (cyc == ebm_pkg::CYC_ONE));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            ready <= 1'b1;
            done <= 1'b0;
            pc <= ebm_pkg::PC_RESET;
            status_flag_register <= ebm_pkg::STATUS_FLAG_REGISTER_RESET;
            result <= 8'h00;
            result_we <= 1'b0;
            product <= 16'h0000;
            product_we <= 1'b0;
            push <= 1'b0;
            push_addr <= 16'h0000;
            pop <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ready <= ready_nxt;
            done <= done_nxt;
            pc <= pc_nxt;
            status_flag_register <= status_flag_register_nxt;
            result <= result_nxt;
            result_we <= result_we_nxt;
            product <= product_nxt;
            product_we <= product_we_nxt;
            push <= push_nxt;
            push_addr <= push_addr_nxt;
            pop <= pop_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_set_ones;
        accept && op == ebm_pkg::op_set_all_ones |=> result == 8'hFF && status_flag_register == $past(status_flag_register) && done;
    endproperty
    a_set_ones: assert property (p_set_ones) else $error("set all ones wrong");

    property p_test_flags;
        accept && op == ebm_pkg::op_test_zero_or_negative |=>
            status_flag_register[ebm_pkg::FLAG_Z] == ($past(rd_val) == 8'h00) && !status_flag_register[ebm_pkg::FLAG_V];
    endproperty
    a_test_flags: assert property (p_test_flags) else $error("test flags wrong");

    property p_mul_value;
        accept && op == ebm_pkg::op_unsigned_product |=>
            product == {8'h00, $past(rd_val)} * {8'h00, $past(rr_val)} && !ready ##1 done;
    endproperty
    a_mul_value: assert property (p_mul_value) else $error("unsigned product wrong");

    property p_frac_value;
        accept && op == ebm_pkg::op_fraction_product_unsigned |=>
            product == 16'({8'h00, $past(rd_val)} * {8'h00, $past(rr_val)} << 1)
            && status_flag_register[ebm_pkg::FLAG_Z] == (product == 16'h0000);
    endproperty
    a_frac_value: assert property (p_frac_value) else $error("fractional product wrong");

    property p_abs_goto;
        accept && op == ebm_pkg::op_absolute_goto |=>
            pc == $past(abs_addr) ##0 !ready [*2] ##1 done;
    endproperty
    a_abs_goto: assert property (p_abs_goto) else $error("absolute goto timing wrong");

    property p_abs_call;
        accept && op == ebm_pkg::op_absolute_subroutine_invoke |=>
            push && push_addr == $past(pc) + 16'h0002 ##0 !ready [*4] ##1 done;
    endproperty
    a_abs_call: assert property (p_abs_call) else $error("absolute call wrong");

    property p_skip_long;
        accept && op == ebm_pkg::op_skip_if_equal && rd_val == rr_val && next_two_word |=>
            pc == $past(pc) + 16'h0003 ##0 !ready [*2] ##1 done;
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("equal skip wrong");

    property p_cmp_carry;
        accept && op == ebm_pkg::op_compare_only |=>
            status_flag_register[ebm_pkg::FLAG_C] == ($past(rd_val) < $past(rr_val)) && done;
    endproperty
    a_cmp_carry: assert property (p_cmp_carry) else $error("compare carry wrong");

    property p_branch_not_taken;
        accept && op == ebm_pkg::op_branch_if_equal && !status_flag_register[ebm_pkg::FLAG_Z] |=>
            pc == $past(pc) + 16'h0001 && done && ready;
    endproperty
    a_branch_not_taken: assert property (p_branch_not_taken) else $error("branch not skipped");

    property p_signed_ge;
        accept && op == ebm_pkg::op_branch_if_signed_ge
            && !(status_flag_register[ebm_pkg::FLAG_N] ^ status_flag_register[ebm_pkg::FLAG_V]) |=>
            pc == $past(rel_tgt) ##0 !ready ##1 done;
    endproperty
    a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong");

    property p_handler_exit;
        accept && op == ebm_pkg::op_interrupt_handler_exit |=>
            status_flag_register[ebm_pkg::FLAG_I] && pop && pc == $past(stack_val) ##0 !ready [*4] ##1 done;
    endproperty
    a_handler_exit: assert property (p_handler_exit) else $error("handler exit wrong");

    c_mul: cover property (accept && op == ebm_pkg::op_signed_product);
    c_taken: cover property (accept && op == ebm_pkg::op_branch_if_overflow_clear ##1 !ready);
    c_skip3: cover property (accept && op == ebm_pkg::op_skip_if_io_bit_high && next_two_word);
    c_call: cover property (accept && op == ebm_pkg::op_relative_subroutine_invoke);
endmodule : ebm_exec
`default_nettype wire

// file: hdl/ebm_pkg.sv
`default_nettype none
package ebm_pkg;
    // Positions of the status_flag_register bits.
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;
    // Reset values and fixed data.
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] STATUS_FLAG_REGISTER_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] STEP_THREE = 16'h0003;
    // Execution lengths in core clock cycles.
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR = 3'h4;
    localparam logic [2:0] CYC_FIVE = 3'h5;

    typedef enum logic [5:0] {
        op_test_zero_or_negative, op_zero_register, op_set_all_ones,
        op_unsigned_product, op_signed_product, op_mixed_sign_product,
        op_fraction_product_unsigned, op_fraction_product_signed,
        op_fraction_product_mixed,
        op_relative_goto, op_indirect_goto, op_absolute_goto,
        op_relative_subroutine_invoke, op_indirect_subroutine_invoke,
        op_absolute_subroutine_invoke, op_subroutine_exit, op_interrupt_handler_exit,
        op_skip_if_equal, op_compare_only, op_compare_with_borrow, op_compare_immediate,
        op_skip_if_reg_bit_low, op_skip_if_reg_bit_high,
        op_skip_if_io_bit_low, op_skip_if_io_bit_high,
        op_branch_if_flag_set, op_branch_if_flag_clear,
        op_branch_if_equal, op_branch_if_not_equal,
        op_branch_if_carry_set, op_branch_if_carry_clear,
        op_branch_if_same_or_higher, op_branch_if_lower,
        op_branch_if_negative, op_branch_if_positive,
        op_branch_if_signed_ge, op_branch_if_signed_lt,
        op_branch_if_half_carry_set, op_branch_if_half_carry_clear,
        op_branch_if_transfer_flag_set, op_branch_if_transfer_flag_clear,
        op_branch_if_overflow_set, op_branch_if_overflow_clear
    } ebm_op_t;
endpackage : ebm_pkg
`default_nettype wire

// file: hdl/ebm_mul.sv
`default_nettype none
module ebm_mul (
    // Operands and their interpretation
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    // Result
    output logic [15:0] product,
    output logic zero,
    output logic carry
);
    logic signed [8:0] sa;
    logic signed [8:0] sb;
    logic signed [17:0] full;
    logic [15:0] raw;

    // Nine-bit operands let one signed multiplier serve all three sign mixes.
    assign sa = $signed({a_signed & a[7], a});
    assign sb = $signed({b_signed & b[7], b});
    assign full = sa * sb;
    assign raw = full[15:0];
    // Carry is taken from the product before the fractional shift drops it.
    assign carry = raw[15];
    assign product = frac ? {raw[14:0], 1'b0} : raw;
    assign zero = (product == 16'h0000);
endmodule : ebm_mul
`default_nettype wire

// file: verification/test_cpu_branch_multiply_exec.sv
`default_nettype none
module test_cpu_branch_multiply_exec;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, issue = 1'b0, ntw = 1'b0;
    ebm_pkg::ebm_op_t op = ebm_pkg::op_set_all_ones;
    logic [7:0] rd = 8'h00, rr = 8'h00, imm = 8'h00, io = 8'h00;
    logic [2:0] bs = 3'h0;
    logic [11:0] k = 12'h000;
    logic [15:0] aa = 16'h0000, zp = 16'h0000, sv = 16'h0000, epc, ret;
    logic ready, done, result_we, product_we, push, pop;
    logic [15:0] pc, product, push_addr;
    logic [7:0] status_flag_register, result, s;
    logic [3:0] p1;
    int mismatches = 0;
    int total_checks = 0;
    ebm_exec ebm_exec_i (.clk(clk), .rst_n(rst_n), .issue(issue), .op(op), .rd_val(rd),
        .rr_val(rr), .imm_val(imm), .bit_sel(bs), .io_val(io), .offset(k), .abs_addr(aa),
        .z_ptr(zp), .stack_val(sv), .next_two_word(ntw), .ready(ready), .done(done),
        .pc(pc), .status_flag_register(status_flag_register), .result(result), .result_we(result_we), .product(product),
        .product_we(product_we), .push(push), .push_addr(push_addr), .pop(pop));
    always #50 clk = ~clk;
    // Seventeen bits so that a pulse can be judged together with a 16-bit address.
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : chk
    task automatic results;
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    // Issues one instruction at a falling edge and counts cycles up to done.
    // With poke set, a second issue is held for the first busy cycle only; it must be ignored.
    task automatic go(input ebm_pkg::ebm_op_t o, input int n, input logic [15:0] npc,
                      input bit poke);
        int c;
        op = o;
        issue = 1'b1;
        @(negedge clk);
        issue = poke;
        if (poke) op = ebm_pkg::op_relative_goto;
        p1 = {result_we, product_we, push, pop};
        c = 1;
        chk("pc", npc, pc);
        while (done !== 1'b1 && c < 8) begin
            @(negedge clk);
            issue = 1'b0;
            c++;
        end
        chk("cycles", n[15:0], c[15:0]);
        if (c >= 8) results();
        chk("pc_end", npc, pc);
        epc = npc;
    endtask : go
    task automatic s_reg;
        rd = 8'h80;
        go(ebm_pkg::op_test_zero_or_negative, 1, epc + 1, 0);
        chk("tst_flags", 4'hA, status_flag_register[4:1]);
        go(ebm_pkg::op_zero_register, 1, epc + 1, 0);
        chk("clr_res", 8'h00, result);
        chk("clr_flags", 4'h1, status_flag_register[4:1]);
        s = status_flag_register;
        go(ebm_pkg::op_set_all_ones, 1, epc + 1, 0);
        chk("ser_res", 8'hFF, result);
        chk("ser_we", 1'b1, p1[3]);
        chk("ser_flags", s, status_flag_register);
    endtask : s_reg
    task automatic mul1(input ebm_pkg::ebm_op_t o, input logic [7:0] a, input logic [7:0] b,
                        input logic [15:0] p, input logic c);
        rd = a;
        rr = b;
        s = status_flag_register;
        go(o, 2, epc + 1, 0);
        chk("prod", p, product);
        chk("prod_we", 1'b1, p1[2]);
        chk("mul_zc", {p == 16'h0000, c}, status_flag_register[1:0]);
        chk("mul_other", s[7:2], status_flag_register[7:2]);
    endtask : mul1
    task automatic s_mul;
        mul1(ebm_pkg::op_unsigned_product, 8'hFF, 8'hFF, 16'hFE01, 1'b1);
        mul1(ebm_pkg::op_signed_product, 8'hFF, 8'hFF, 16'h0001, 1'b0);
        mul1(ebm_pkg::op_mixed_sign_product, 8'hFF, 8'hFF, 16'hFF01, 1'b1);
        mul1(ebm_pkg::op_unsigned_product, 8'h00, 8'h37, 16'h0000, 1'b0);
        mul1(ebm_pkg::op_fraction_product_unsigned, 8'hFF, 8'hFF, 16'hFC02, 1'b1);
        mul1(ebm_pkg::op_fraction_product_signed, 8'h80, 8'h80, 16'h8000, 1'b0);
        mul1(ebm_pkg::op_fraction_product_mixed, 8'hC0, 8'h80, 16'hC000, 1'b1);
    endtask : s_mul
    function automatic bit tk(input ebm_pkg::ebm_op_t o, input logic [7:0] f);
        case (o)
            ebm_pkg::op_branch_if_flag_set: return f[bs] == 1'b1;
            ebm_pkg::op_branch_if_flag_clear: return f[bs] == 1'b0;
            ebm_pkg::op_branch_if_equal: return f[1] == 1'b1;
            ebm_pkg::op_branch_if_not_equal: return f[1] == 1'b0;
            ebm_pkg::op_branch_if_carry_set, ebm_pkg::op_branch_if_lower: return f[0];
            ebm_pkg::op_branch_if_negative: return f[2] == 1'b1;
            ebm_pkg::op_branch_if_positive: return f[2] == 1'b0;
            ebm_pkg::op_branch_if_signed_ge: return (f[2] ^ f[3]) == 1'b0;
            ebm_pkg::op_branch_if_signed_lt: return (f[2] ^ f[3]) == 1'b1;
            ebm_pkg::op_branch_if_half_carry_set: return f[5] == 1'b1;
            ebm_pkg::op_branch_if_half_carry_clear: return f[5] == 1'b0;
            ebm_pkg::op_branch_if_transfer_flag_set: return f[6] == 1'b1;
            ebm_pkg::op_branch_if_transfer_flag_clear: return f[6] == 1'b0;
            ebm_pkg::op_branch_if_overflow_set: return f[3] == 1'b1;
            ebm_pkg::op_branch_if_overflow_clear: return f[3] == 1'b0;
            default: return f[0] == 1'b0;
        endcase
    endfunction : tk
    // Every branch is run against the flags that the bench itself predicted.
    task automatic br_all(input logic [7:0] f);
        ebm_pkg::ebm_op_t o;
        bs = 3'h3;
        k = 12'h003;
        for (int i = ebm_pkg::op_branch_if_flag_set; i <= ebm_pkg::op_branch_if_overflow_clear;
             i++) begin
            o = ebm_pkg::ebm_op_t'(i);
            if (tk(o, f)) go(o, 2, epc + 4, 0);
            else go(o, 1, epc + 1, 0);
            chk("br_flags", f, status_flag_register);
        end
    endtask : br_all
    task automatic cmp(input ebm_pkg::ebm_op_t o, input logic [7:0] a, input logic [7:0] b,
                       input logic [5:0] f);
        rd = a;
        rr = b;
        imm = b;
        go(o, 1, epc + 1, 0);
        chk("cmp_flags", f, status_flag_register[5:0]);
        chk("cmp_we", 2'h0, p1[3:2]);
    endtask : cmp
    task automatic s_cmp;
        cmp(ebm_pkg::op_compare_only, 8'h10, 8'h20, 6'h15);
        cmp(ebm_pkg::op_compare_with_borrow, 8'h10, 8'h0F, 6'h20);
        cmp(ebm_pkg::op_compare_only, 8'h80, 8'h01, 6'h38);
        br_all(8'h38);
        cmp(ebm_pkg::op_compare_immediate, 8'h05, 8'h05, 6'h02);
        br_all(8'h02);
    endtask : s_cmp
    task automatic sk(input ebm_pkg::ebm_op_t o, input bit t, input bit two);
        int n;
        n = t ? (two ? 3 : 2) : 1;
        ntw = two;
        s = status_flag_register;
        go(o, n, epc + n[15:0], 0);
        chk("skip_flags", s, status_flag_register);
    endtask : sk
    task automatic s_skip;
        rd = 8'h05;
        rr = 8'h05;
        sk(ebm_pkg::op_skip_if_equal, 1, 1);
        sk(ebm_pkg::op_skip_if_equal, 1, 0);
        rr = 8'h06;
        sk(ebm_pkg::op_skip_if_equal, 0, 1);
        rr = 8'h04;
        bs = 3'h2;
        sk(ebm_pkg::op_skip_if_reg_bit_low, 0, 0);
        sk(ebm_pkg::op_skip_if_reg_bit_high, 1, 1);
        bs = 3'h3;
        sk(ebm_pkg::op_skip_if_reg_bit_low, 1, 0);
        sk(ebm_pkg::op_skip_if_reg_bit_high, 0, 0);
        io = 8'h80;
        bs = 3'h7;
        sk(ebm_pkg::op_skip_if_io_bit_low, 0, 1);
        sk(ebm_pkg::op_skip_if_io_bit_high, 1, 0);
        bs = 3'h0;
        sk(ebm_pkg::op_skip_if_io_bit_low, 1, 1);
        sk(ebm_pkg::op_skip_if_io_bit_high, 0, 0);
    endtask : s_skip
    task automatic s_flow;
        s = status_flag_register;
        k = 12'hFFE;
        go(ebm_pkg::op_relative_goto, 2, epc + 16'hFFFF, 0);
        zp = 16'h1234;
        go(ebm_pkg::op_indirect_goto, 2, 16'h1234, 0);
        aa = 16'h0456;
        go(ebm_pkg::op_absolute_goto, 3, 16'h0456, 1);
        k = 12'h005;
        ret = epc + 1;
        go(ebm_pkg::op_relative_subroutine_invoke, 4, epc + 6, 0);
        chk("relative_subroutine_invoke_push", {1'b1, ret}, {p1[1], push_addr});
        ret = epc + 1;
        zp = 16'h2000;
        go(ebm_pkg::op_indirect_subroutine_invoke, 4, 16'h2000, 0);
        chk("indirect_subroutine_invoke_push", {1'b1, ret}, {p1[1], push_addr});
        ret = epc + 2;
        aa = 16'h0300;
        go(ebm_pkg::op_absolute_subroutine_invoke, 5, 16'h0300, 0);
        chk("call_push", {1'b1, ret}, {p1[1], push_addr});
        chk("flow_flags", s, status_flag_register);
        sv = 16'h0111;
        go(ebm_pkg::op_subroutine_exit, 5, 16'h0111, 0);
        chk("ret_pop", 1'b1, p1[0]);
        sv = 16'h0222;
        go(ebm_pkg::op_interrupt_handler_exit, 5, 16'h0222, 0);
        chk("interrupt_handler_exit_flags", {1'b1, s[6:0]}, status_flag_register);
    endtask : s_flow
    initial begin
        repeat (20) @(negedge clk);
        chk("rst_pc", 16'h0000, pc);
        chk("rst_ready", 1'b1, ready);
        rst_n = 1'b1;
        epc = 16'h0000;
        @(negedge clk);
        s_reg();
        s_mul();
        s_cmp();
        s_skip();
        s_flow();
        results();
    end
endmodule : test_cpu_branch_multiply_exec
`default_nettype wire
